// *** design/tps_map.svh ***
`ifndef TPS_MAP_SVH
`define TPS_MAP_SVH
// Operation
// (RL1) Counter clock from a selectable source.
// (RL2) Select code 101 feeds no clock.
// (RL3) Fixed encoding of the eight select codes.
// (RL4) Separate interrupt per comparator A and P.
// (RL5) Match may clear counter and change output.
// (RL6) Clock pin taken only when selected.
// (RL7) Clock pin counts rising or falling edge.
// (RL8) Compare match sets, clears or toggles output.
// (RL9) PWM waveform leaves on the same pins.
// (RL10) Pin pair inverted by port data bits.
// (RL11) Set enable routes pin to the timer.
// (RL12) First pin register layout and reset, full.
// (RL13) Second pin register layout and reset, full.
// (RL14) Reduced first register keeps bits 4, 0.
// (RL15) Reduced second register keeps bits 5, 1.
// (RL16) Unimplemented pin enable bits read zero.
// (RL17) Counter and compare A split into bytes.
// (RL18) Low bytes move through a holding buffer.
// (RL19) Low write buffers; high write commits both.
// (RL20) High read latches low into the buffer.
// (RL21) Software writes low first, reads high first.
// (RL22) Capture mode enables one input pin only; the code sets pin enables from the pin registers alone, in every mode.
// (RL23) Each timer owns its holding buffer.

// ****************************************
// Register offsets
// ****************************************
`define TPS_OFF_C0 3'h0
`define TPS_OFF_C1 3'h1
`define TPS_OFF_DL 3'h2
`define TPS_OFF_DH 3'h3
`define TPS_OFF_AL 3'h4
`define TPS_OFF_AH 3'h5
`define TPS_OFF_PC0 6'h20
`define TPS_OFF_PC1 6'h21

// ****************************************
// Field positions
// ****************************************
`define TPS_C0_ON 3
`define TPS_C1_OC 3
`define TPS_C1_POL 2
`define TPS_C1_CCLR 0

// ****************************************
// Reset values and implemented bit masks
// ****************************************
`define TPS_PC_RST 8'h11
`define TPS_PC_FULL 8'h33
`define TPS_PC0_RED 8'h11
`define TPS_PC1_RED 8'h22

// ****************************************
// Prescaler terminal counts
// ****************************************
`define TPS_DIV4_END 2'h3
`define TPS_DIV16_END 4'hF
`define TPS_DIV64_END 6'h3F
`endif

// *** design/tps_pkg.sv ***
package tps_pkg;
   // Counter clock select codes.
   typedef enum logic [2:0] {
      TPS_CK_SYS4 = 3'h0,
      TPS_CK_SYS  = 3'h1,
      TPS_CK_H16  = 3'h2,
      TPS_CK_H64  = 3'h3,
      TPS_CK_TBC  = 3'h4,
      TPS_CK_NONE = 3'h5,
      TPS_CK_RISE = 3'h6,
      TPS_CK_FALL = 3'h7
   } tps_ck_t;
   // Output action on a comparator A match.
   typedef enum logic [1:0] {
      TPS_IO_KEEP = 2'h0,
      TPS_IO_LOW  = 2'h1,
      TPS_IO_HIGH = 2'h2,
      TPS_IO_TGL  = 2'h3
   } tps_io_t;
   // Operating mode field.
   typedef enum logic [1:0] {
      TPS_M_CMP = 2'h0,
      TPS_M_TMR = 2'h1,
      TPS_M_PWM = 2'h2,
      TPS_M_CAP = 2'h3
   } tps_mode_t;
   // Whole state of the shell.
   typedef struct packed {
      logic [3:0][7:0]  c0;
      logic [3:0][7:0]  c1;
      logic [3:0][15:0] cnt;
      logic [3:0][15:0] compare_a_value;
      logic [3:0][7:0]  hold;
      logic [3:0]       out;
      logic [3:0]       on_d;
      logic [3:0]       irq_a;
      logic [3:0]       irq_p;
      logic [7:0]       tp;
      logic [7:0]       pc0;
      logic [7:0]       pc1;
      logic [5:0]       pre;
      logic             tb_d;
      logic [7:0]       rdata;
   } tps_state_t;
   // State of one clock selector.
   typedef struct packed {
      logic pin_d;
   } tps_sel_state_t;
endpackage

// *** design/tps_tick_sel.sv ***
`timescale 1ns/1ps
// ****************************************
// Counter clock selector for one timer
// ****************************************
module tps_tick_sel
   import tps_pkg::*;
(
   input  wire logic       clk,
   input  wire logic       resetn,
   input  wire logic [2:0] sel,
   input  wire logic       en4,
   input  wire logic       en16,
   input  wire logic       en64,
   input  wire logic       tb_tick,
   input  wire logic       pin,
   output logic            tick,
   output logic            pin_taken
);
   tps_sel_state_t q;      // Registered state.
   tps_sel_state_t d;      // Next state.

   // Pick one enable pulse per clock; code 101 gives none.
   always_comb begin
      d.pin_d = pin;
      case (tps_ck_t'(sel))
         TPS_CK_SYS4: tick = en4;                 // RL3
         TPS_CK_SYS:  tick = 1'b1;                // RL1
         TPS_CK_H16:  tick = en16;
         TPS_CK_H64:  tick = en64;
         TPS_CK_TBC:  tick = tb_tick;
         TPS_CK_NONE: tick = 1'b0;                // RL2
         TPS_CK_RISE: tick = pin & ~q.pin_d;      // RL7
         TPS_CK_FALL: tick = ~pin & q.pin_d;      // RL7
         default:     tick = 1'b0;
      endcase
      // The pin leaves its shared function only for the edge codes.
      pin_taken = (sel[2:1] == 2'h3);             // RL6
   end

   // The pin is taken as synchronous, so one flop finds the edge.
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end
endmodule

// *** design/tps_shell.sv ***
// The register addresses and the strobed register port were chosen for this implementation.
`timescale 1ns/1ps
`include "tps_map.svh"
// ****************************************
// Timer pin and access shell, four timers
// ****************************************
module tps_shell
   import tps_pkg::*;
#(
   parameter bit PC0_FULL = 1'b1,   // First pin register, full layout.
   parameter bit PC1_FULL = 1'b1    // Second pin register, full layout.
)(
   input  wire logic       CLK,
   input  wire logic       RESETN,
   input  wire logic [5:0] ADDR,
   input  wire logic [7:0] WDATA,
   input  wire logic       WR,
   input  wire logic       RD,
   output logic      [7:0] RDATA,
   input  wire logic       TB_CLK,
   input  wire logic [3:0] TCK,
   input  wire logic [7:0] PORT_DATA,
   output logic      [7:0] TP_OUT,
   output logic      [7:0] TP_OE,
   output logic      [3:0] TCK_SEL,
   output logic      [3:0] IRQ_A,
   output logic      [3:0] IRQ_P
);
   // Implemented bits of each pin register for this variant.
   localparam logic [7:0] PC0_MASK = PC0_FULL ? `TPS_PC_FULL : `TPS_PC0_RED;
   localparam logic [7:0] PC1_MASK = PC1_FULL ? `TPS_PC_FULL : `TPS_PC1_RED;

   tps_state_t q;          // Registered state.
   tps_state_t d;          // Next state.
   logic [3:0] tick;       // Counter clock enables.
   logic       en4;        // System clock over 4.
   logic       en16;       // High clock over 16.
   logic       en64;       // High clock over 64.
   logic       tb_tick;    // Time-base rising edge.

   // ****************************************
   // Helper functions
   // ****************************************
   // Counter width mask: timer 0 is 16 bits, the rest 10 bits.
   function automatic logic [15:0] cmask(input int i);
      return (i == 0) ? 16'hFFFF : 16'h03FF;       // RL17
   endfunction

   // Top three counter bits, which comparator P looks at.
   function automatic logic [2:0] top3(input logic [15:0] v, input int i);
      return (i == 0) ? v[15:13] : v[9:7];
   endfunction

   // Comparator P hit; zero means a full count, matched at wrap.
   function automatic logic pmatch(input logic [15:0] v,
                                   input logic [2:0] rp, input int i);
      logic [15:0] low;
      low = v & (cmask(i) >> 3);
      if (rp == 3'h0) begin
         return v == 16'h0000;
      end
      return (top3(v, i) == rp) && (low == 16'h0000);
   endfunction

   // Pin enable of pin k of timer i from the two pin registers.
   function automatic logic pin_en(input int i, input int k,
                                   input logic [7:0] r0, input logic [7:0] r1);
      logic [7:0] r;
      r = (i < 2) ? r0 : r1;
      return r[(i % 2) * 4 + k];                   // RL12 RL13
   endfunction

   // ****************************************
   // Clock enables
   // ****************************************
   // One free prescaler serves all ratios, so every timer on the
   // same ratio sees its enable in the same cycle.
   assign en4  = (q.pre[1:0] == `TPS_DIV4_END);
   assign en16 = (q.pre[3:0] == `TPS_DIV16_END);
   assign en64 = (q.pre == `TPS_DIV64_END);
   assign tb_tick = TB_CLK & ~q.tb_d;

   // One clock selector per timer.
   for (genvar g = 0; g < 4; g++) begin : g_sel
      tps_tick_sel u_sel (
         .clk       (CLK),
         .resetn    (RESETN),
         .sel       (q.c0[g][6:4]),
         .en4       (en4),
         .en16      (en16),
         .en64      (en64),
         .tb_tick   (tb_tick),
         .pin       (TCK[g]),
         .tick      (tick[g]),
         .pin_taken (TCK_SEL[g])
      );
   end

   // ****************************************
   // Next state
   // ****************************************
   always_comb begin
      logic [15:0] inc;      // Counter plus one, wrapped.
      logic        ma;       // Comparator A hit.
      logic        mp;       // Comparator P hit.
      logic [1:0]  t;        // Addressed timer.
      inc = '0;
      ma = 1'b0;
      mp = 1'b0;
      t = ADDR[4:3];
      d = q;
      d.pre = q.pre + 6'h01;
      d.tb_d = TB_CLK;
      d.irq_a = '0;
      d.irq_p = '0;
      d.rdata = 8'h00;
      for (int i = 0; i < 4; i++) begin
         inc = (q.cnt[i] + 16'h0001) & cmask(i);
         d.on_d[i] = q.c0[i][`TPS_C0_ON];
         if (q.c0[i][`TPS_C0_ON] && !q.on_d[i]) begin
            // Switching on restarts the count and the output level.
            d.cnt[i] = '0;
            d.out[i] = q.c1[i][`TPS_C1_OC];
         end else if (q.c0[i][`TPS_C0_ON] && tick[i]) begin
            ma = (inc == q.compare_a_value[i]);
            mp = pmatch(inc, q.c0[i][2:0], i);
            d.irq_a[i] = ma;                                 // RL4
            d.irq_p[i] = mp;                                 // RL4
            // The clear source is comparator A or P, never both.
            if (q.c1[i][`TPS_C1_CCLR] ? ma : mp) begin
               d.cnt[i] = '0;                                // RL5
            end else begin
               d.cnt[i] = inc;                               // RL1
            end
            if (ma && tps_mode_t'(q.c1[i][7:6]) == TPS_M_CMP) begin
               case (tps_io_t'(q.c1[i][5:4]))
                  TPS_IO_LOW:  d.out[i] = 1'b0;              // RL8
                  TPS_IO_HIGH: d.out[i] = 1'b1;              // RL8
                  TPS_IO_TGL:  d.out[i] = ~q.out[i];         // RL8 RL5
                  default:     d.out[i] = q.out[i];
               endcase
            end
         end
         // PWM is high while the count is below compare A, low instead when the polarity bit is set.
         if (tps_mode_t'(q.c1[i][7:6]) == TPS_M_PWM) begin
            d.out[i] = (q.cnt[i] < q.compare_a_value[i]) ^ q.c1[i][`TPS_C1_POL]; // RL9
         end
      end

      // ****************************************
      // Register writes
      // ****************************************
      // Counter bytes are read-only; their writes are dropped.
      if (WR && !ADDR[5]) begin
         case (ADDR[2:0])
            `TPS_OFF_C0: d.c0[t] = WDATA;
            `TPS_OFF_C1: d.c1[t] = WDATA;
            `TPS_OFF_AL: d.hold[t] = WDATA;                  // RL19 RL23
            `TPS_OFF_AH: begin
               d.compare_a_value[t] = {WDATA, q.hold[t]} & cmask(32'(t)); // RL19 RL18
            end
            default: d.c0[t] = q.c0[t];
         endcase
      end else if (WR && ADDR == `TPS_OFF_PC0) begin
         d.pc0 = WDATA & PC0_MASK;                           // RL14 RL16
      end else if (WR && ADDR == `TPS_OFF_PC1) begin
         d.pc1 = WDATA & PC1_MASK;                           // RL15 RL16
      end

      // ****************************************
      // Register reads
      // ****************************************
      // Unmapped addresses answer zero.
      if (RD && !ADDR[5]) begin
         case (ADDR[2:0])
            `TPS_OFF_C0: d.rdata = q.c0[t];
            `TPS_OFF_C1: d.rdata = q.c1[t];
            `TPS_OFF_DH: begin
               d.rdata = q.cnt[t][15:8];                     // RL17
               d.hold[t] = q.cnt[t][7:0];                    // RL20 RL18
            end
            `TPS_OFF_AH: begin
               d.rdata = q.compare_a_value[t][15:8];
               d.hold[t] = q.compare_a_value[t][7:0];                   // RL20
            end
            `TPS_OFF_DL: d.rdata = q.hold[t];                // RL20
            `TPS_OFF_AL: d.rdata = q.hold[t];                // RL20
            default: d.rdata = 8'h00;
         endcase
      end else if (RD && ADDR == `TPS_OFF_PC0) begin
         d.rdata = q.pc0;
      end else if (RD && ADDR == `TPS_OFF_PC1) begin
         d.rdata = q.pc1;
      end

      // ****************************************
      // Pin levels
      // ****************************************
      // Each pin carries its timer output, inverted by its port bit,
      // so opposite port bits give a complementary pair.
      for (int p = 0; p < 8; p++) begin
         d.tp[p] = d.out[p / 2] ^ PORT_DATA[p];              // RL10 RL9
      end
   end

   // ****************************************
   // State register
   // ****************************************
   always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         q <= '0;
         q.pc0 <= `TPS_PC_RST & PC0_MASK;                    // RL12 RL14
         q.pc1 <= `TPS_PC_RST & PC1_MASK;                    // RL13 RL15
      end else begin
         q <= d;
      end
   end

   // ****************************************
   // Outputs
   // ****************************************
   // A cleared enable leaves the pin to its shared function.
   always_comb begin
      for (int p = 0; p < 8; p++) begin
         TP_OE[p] = pin_en(p / 2, p % 2, q.pc0, q.pc1);      // RL11
      end
   end
   assign TP_OUT = q.tp;
   assign RDATA = q.rdata;
   assign IRQ_A = q.irq_a;
   assign IRQ_P = q.irq_p;

   // ****************************************
   // Assertions
   // ****************************************
   default clocking cb @(posedge CLK); endclocking
   default disable iff (!RESETN);

   // Code 101 freezes a running counter.
   a_none_freezes: assert property ( // RL2
      (q.c0[0][6:4] == 3'h5 && q.on_d[0] && q.c0[0][`TPS_C0_ON])
      |=> q.cnt[0] == $past(q.cnt[0]))
      else $error("counter moved with no clock selected");

   // System over four ticks exactly every fourth cycle.
   a_sys4_rate: assert property ( // RL3
      (q.c0[1][6:4] == 3'h0) [*5] ##0 (tick[1] && $past(RESETN, 4))
      |-> $past(tick[1], 4) && !$past(tick[1]) && !$past(tick[1], 2) && !$past(tick[1], 3))
      else $error("divide by four spacing wrong");

   // A rising pin edge ticks the counter in the same cycle.
   a_ext_rise: assert property ( // RL7
      (q.c0[2][6:4] == 3'h6 && TCK[2] && !$past(TCK[2])) |-> tick[2])
      else $error("rising pin edge lost");

   // Compare A hit raises its request one cycle later.
   a_irq_a_match: assert property ( // RL4
      (q.c0[1][`TPS_C0_ON] && q.on_d[1] && tick[1]
       && ((q.cnt[1] + 16'h0001) & 16'h03FF) == q.compare_a_value[1]) |=> IRQ_A[1])
      else $error("compare A request missing");

   // Clear on A leaves the counter at zero with the request.
   a_clear_on_a: assert property ( // RL5
      (IRQ_A[1] && $past(q.c1[1][`TPS_C1_CCLR])) |-> q.cnt[1] == 16'h0000)
      else $error("counter not cleared on compare A");

   // Toggle action flips the output on each A hit.
   a_toggle_out: assert property ( // RL8
      (IRQ_A[1] && $past(q.c1[1][7:4]) == 4'h3) |-> q.out[1] != $past(q.out[1]))
      else $error("output did not toggle");

   // The two pins of a timer differ as their port bits differ.
   a_pair_invert: assert property ( // RL10
      (TP_OUT[2] ^ TP_OUT[3]) == $past(PORT_DATA[2] ^ PORT_DATA[3]))
      else $error("pin pair inversion wrong");

   // Pin registers come out of reset at their defaults.
   a_pc_reset: assert property ( // RL12
      $rose(RESETN) |-> (q.pc0 == (8'h11 & PC0_MASK) && q.pc1 == (8'h11 & PC1_MASK)))
      else $error("pin register reset value wrong");

   // Unimplemented pin bits never hold a one.
   a_pc_unimpl: assert property ( // RL16
      (q.pc0 & ~PC0_MASK) == 8'h00 && (q.pc1 & ~PC1_MASK) == 8'h00)
      else $error("unimplemented pin bit set");

   // High write commits the buffered low byte.
   a_ah_commit: assert property ( // RL19
      (WR && ADDR == 6'h0D) |=> q.compare_a_value[1] == $past({WDATA[1:0], q.hold[1]}))
      else $error("compare A commit wrong");

   // Low write touches only the own buffer.
   a_al_buffer: assert property ( // RL23
      (WR && ADDR == 6'h0C) |=> q.compare_a_value[1] == $past(q.compare_a_value[1])
      && q.hold[1] == $past(WDATA) && q.hold[2] == $past(q.hold[2]))
      else $error("low write leaked");

   // High read returns the high byte and latches the low byte.
   a_dh_latch: assert property ( // RL20
      (RD && ADDR == 6'h0B) |=> RDATA == $past(q.cnt[1][15:8])
      && q.hold[1] == $past(q.cnt[1][7:0]))
      else $error("high read latch wrong");

   c_irq_a: cover property (IRQ_A[0]);
   c_irq_p: cover property (IRQ_P[1]);
   c_ext_fall: cover property (q.c0[3][6:4] == 3'h7 && tick[3]);
   c_pwm: cover property (q.c1[2][7:6] == 2'h2 && $rose(q.out[2]));
endmodule

// *** verif/tps_shell_test.sv ***
`timescale 1ns/1ps
// ****************************************
// Bench for the timer pin and access shell
// ****************************************
module timer_pin_and_access_shell_test;
   logic       CLK       = 1'b0;  // System clock, 50 MHz.
   logic       RESETN    = 1'b0;  // Asynchronous reset, active low.
   logic [5:0] ADDR      = 6'h00; // Register address.
   logic [7:0] WDATA     = 8'h00; // Write data.
   logic       WR        = 1'b0;  // Write strobe.
   logic       RD        = 1'b0;  // Read strobe.
   logic [3:0] TCK       = 4'h0;  // External clock pins.
   logic [7:0] PORT_DATA = 8'h00; // Port data inversion bits.
   logic [2:0] tb_div    = 3'h0;  // Divider for the time-base clock.
   logic [7:0] RDATA, RDATA_R, TP_OUT, TP_OE, TP_OE_R;
   logic [3:0] TCK_SEL, IRQ_A, IRQ_P;
   logic [7:0] last_r, dh, dl;    // Reduced-instance read, counter bytes.
   int         n_fail = 0;
   int         checks_done = 0;
   int         n_irq_a = 0;       // Compare A pulses of timer 2.
   int         n_irq_p = 0;       // Compare P pulses of timer 3.
   int         div_tab [5] = '{4, 1, 16, 64, 8};
   int         est;
   wire        TB_CLK = tb_div[2];

   // Full layout instance under test.
   tps_shell #(.PC0_FULL(1'b1), .PC1_FULL(1'b1)) u_dut (
      .CLK(CLK), .RESETN(RESETN), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
      .RDATA(RDATA), .TB_CLK(TB_CLK), .TCK(TCK), .PORT_DATA(PORT_DATA),
      .TP_OUT(TP_OUT), .TP_OE(TP_OE), .TCK_SEL(TCK_SEL), .IRQ_A(IRQ_A), .IRQ_P(IRQ_P));
   // Reduced layout instance; it shares every input, so only its pin registers are judged.
   tps_shell #(.PC0_FULL(1'b0), .PC1_FULL(1'b0)) u_red (
      .CLK(CLK), .RESETN(RESETN), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
      .RDATA(RDATA_R), .TB_CLK(TB_CLK), .TCK(TCK), .PORT_DATA(PORT_DATA),
      .TP_OUT(), .TP_OE(TP_OE_R), .TCK_SEL(), .IRQ_A(), .IRQ_P());

   // ****************************************
   // Clock, time base and pulse counters
   // ****************************************
   initial begin
      forever #10 CLK = ~CLK;
   end
   // The time base ticks once every eight system cycles.
   always @(posedge CLK) begin
      tb_div <= tb_div + 3'h1;
      if (IRQ_A[2] === 1'b1) begin
         n_irq_a++;
      end
      if (IRQ_P[3] === 1'b1) begin
         n_irq_p++;
      end
   end

   // ****************************************
   // Bus, pin and compare tasks
   // ****************************************
   task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
      checks_done++;
      if (got !== exp) begin
         n_fail++;
         $display("CHECK FAILED at %0t: got %h, expected %h", $time, got, exp);
      end
   endtask
   task automatic chk_int(input int got, input int exp);
      checks_done++;
      if (got != exp) begin
         n_fail++;
         $display("CHECK FAILED at %0t: count %0d, expected %0d", $time, got, exp);
      end
   endtask
   // Each bus task sets both strobes once before its first clock edge, so no strobe is assigned twice in a step.
   task automatic wr(input logic [5:0] a, input logic [7:0] d);
      ADDR  <= a;
      WDATA <= d;
      WR    <= 1'b1;
      RD    <= 1'b0;
      @(posedge CLK);
   endtask
   // Read data stand only in the cycle after the strobe, so they are taken there.
   task automatic rd(input logic [5:0] a, output logic [7:0] d);
      ADDR <= a;
      WR   <= 1'b0;
      RD   <= 1'b1;
      @(posedge CLK);
      RD   <= 1'b0;
      @(posedge CLK);
      d      = RDATA;
      last_r = RDATA_R;
   endtask
   task automatic rdc(input logic [5:0] a, input logic [7:0] exp);
      logic [7:0] d;
      rd(a, d);
      chk8(d, exp);
   endtask
   task automatic idle();
      WR <= 1'b0;
      RD <= 1'b0;
      @(posedge CLK);
   endtask
   // Slow pulses leave room for the pin edge flop and the registered outputs.
   task automatic pulse(input int t, input int n);
      repeat (n) begin
         TCK[t] <= 1'b1;
         repeat (2) @(posedge CLK);
         TCK[t] <= 1'b0;
         repeat (4) @(posedge CLK);
      end
   endtask
   task automatic end_of_test();
      $display("Comparisons %0d, mismatches %0d", checks_done, n_fail);
      if (n_fail == 0 && checks_done > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   // ****************************************
   // Main sequence
   // ****************************************
   initial begin
      repeat (2) @(posedge CLK);
      RESETN <= 1'b1;
      @(posedge CLK);
      // Reset values of the pin routing, both layouts.
      chk8(TP_OE, 8'h55);
      chk8(TP_OE_R, 8'h05);
      rdc(6'h20, 8'h11);
      chk8(last_r, 8'h11);
      rdc(6'h21, 8'h11);
      chk8(last_r, 8'h00);
      // Writing all ones shows which bits exist.
      wr(6'h20, 8'hFF);
      wr(6'h21, 8'hFF);
      rdc(6'h20, 8'h33);
      chk8(last_r, 8'h11);
      rdc(6'h21, 8'h33);
      chk8(last_r, 8'h22);
      chk8(TP_OE, 8'hFF);
      chk8(TP_OE_R, 8'hA5);
      rdc(6'h3F, 8'h00);
      wr(6'h20, 8'h00);
      idle();
      chk8(TP_OE, 8'hF0);
      // Buffered compare A access on two timers at once.
      wr(6'h04, 8'h34);
      wr(6'h0C, 8'h5A);
      wr(6'h05, 8'h12);
      wr(6'h0D, 8'hFF);
      rdc(6'h05, 8'h12);
      rdc(6'h0D, 8'h03);
      rdc(6'h04, 8'h34);
      rdc(6'h0C, 8'h5A);
      // A low write alone must not reach the stored value.
      wr(6'h04, 8'h99);
      rdc(6'h05, 8'h12);
      rdc(6'h04, 8'h34);
      // Code 101 freezes the counter; pin codes count edges.
      wr(6'h00, 8'h58);
      idle();
      pulse(0, 2);
      chk8({4'h0, TCK_SEL}, 8'h00);
      rdc(6'h03, 8'h00);
      rdc(6'h02, 8'h00);
      wr(6'h00, 8'h68);
      idle();
      chk8({4'h0, TCK_SEL}, 8'h01);
      pulse(0, 5);
      rdc(6'h03, 8'h00);
      rdc(6'h02, 8'h05);
      wr(6'h00, 8'h78);
      idle();
      pulse(0, 3);
      rdc(6'h03, 8'h00);
      rdc(6'h02, 8'h08);
      // Internal sources: the count over 128 cycles follows the ratio; phase allows slack.
      for (int k = 0; k < 5; k++) begin
         wr(6'h08, 8'h00);
         wr(6'h08, {1'b0, 3'(k), 4'h8});
         idle();
         repeat (128) @(posedge CLK);
         rd(6'h0B, dh);
         rd(6'h0A, dl);
         est = 128 / div_tab[k] - int'({dh[1:0], dl});
         chk_int(int'(est >= -3 && est <= 3), 1);
      end
      wr(6'h08, 8'h00);
      // Timer 2: match at 3 toggles the pins and clears the counter.
      wr(6'h14, 8'h03);
      wr(6'h15, 8'h00);
      wr(6'h11, 8'h31);
      wr(6'h10, 8'h68);
      idle();
      pulse(2, 3);
      chk_int(n_irq_a, 1);
      chk8(TP_OUT & 8'h30, 8'h30);
      PORT_DATA <= 8'h20;
      repeat (2) @(posedge CLK);
      chk8(TP_OUT & 8'h30, 8'h10);
      pulse(2, 3);
      chk_int(n_irq_a, 2);
      chk8(TP_OUT & 8'h30, 8'h20);
      // Timer 3: period of 128 system cycles from compare P.
      wr(6'h18, 8'h19);
      idle();
      repeat (400) @(posedge CLK);
      chk_int(n_irq_p, 3);
      end_of_test();
   end
endmodule
